//--- verilog/dscal_pkg.sv
// constants and helpers shared by the dual-channel self-calibration controller
package dscal_pkg;

  // ************************************************************
  // register map (register port, 5-bit address, 8-bit data)
  // ************************************************************
  localparam logic [4:0] CLK_SEL_CTRL_ADDR = 5'h0E;
  localparam logic [4:0] CAL_STATUS_ADDR = 5'h0F;
  localparam logic [4:0] RUN_CTRL_ADDR = 5'h12;

  // calibration_clock_select_control fields
  localparam int DIVSEL_LSB = 0;
  localparam int DIVSEL_W = 3;
  localparam int CLK_EN_BIT = 3;
  localparam int I_SEL_BIT = 4;
  localparam int Q_SEL_BIT = 5;

  // calibration_run_control fields
  localparam int Q_UNCAL_BIT = 0;
  localparam int I_UNCAL_BIT = 1;
  localparam int START_BIT = 4;

  // status fields
  localparam int I_DONE_BIT = 6;
  localparam int Q_DONE_BIT = 7;

  // reset values
  localparam logic [7:0] CLK_SEL_CTRL_RST = 8'h00;
  localparam logic [7:0] RUN_CTRL_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int PRE_DIV = 16;
  localparam int PERIOD_W = 12;
  localparam int CAL_RUN_CYCLES = 300;
  localparam int CAL_CNT_W = 9;
  localparam int DAC_BITS = 14;

  // period in reference clocks: pre-divider times 2^(code+1), 32 .. 2048;
  // the top code saturates at 2048, since one more doubling leaves the legal range
  function automatic logic [PERIOD_W-1:0] cal_period(input logic [DIVSEL_W-1:0] code);
    logic [PERIOD_W-1:0] base;
    logic [3:0] shift;
    base = PERIOD_W'(PRE_DIV);
    shift = (code == 3'h7) ? 4'h7 : {1'b0, code} + 4'h1;
    return base << shift;
  endfunction

endpackage

//--- verilog/dscal_divider.sv
// calibration clock divider: one tick per calibration clock period
`timescale 1ns/1ps

module dscal_divider
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic enable_i,
  input wire logic [dscal_pkg::DIVSEL_W-1:0] divide_select_i,
  // outputs
  output logic cal_tick_o,
  output logic cal_clk_o
);

  logic [dscal_pkg::PERIOD_W-1:0] cnt_q;
  logic [dscal_pkg::PERIOD_W-1:0] period;

  assign period = dscal_pkg::cal_period(divide_select_i);
  // tick on the last reference cycle of each period, never while gated
  assign cal_tick_o = enable_i && (cnt_q == period - 12'h001);

  // ************************************************************
  // period counter
  // ************************************************************
  // held at zero while disabled so a fresh enable starts a full period
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_q <= 12'h000;
    else if (!enable_i || cal_tick_o)
      cnt_q <= 12'h000;
    else if (cnt_q >= period - 12'h001)
      cnt_q <= 12'h000; // divider changed under us, restart
    else
      cnt_q <= cnt_q + 12'h001;
  end

  // visible calibration clock, high for the first half of each period
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cal_clk_o <= 1'b0;
    else
      cal_clk_o <= enable_i && (cnt_q < (period >> 1));
  end

  AST_TICK_GATED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !enable_i |-> !cal_tick_o)
    else $error("calibration tick while clock disabled");

endmodule // dscal_divider

//--- verilog/dscal_engine.sv
// one channel's calibration engine: runs a fixed number of calibration ticks
`timescale 1ns/1ps

module dscal_engine
#(
  parameter int CAL_CYCLES = dscal_pkg::CAL_RUN_CYCLES
)
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic start_i,
  input wire logic select_i,
  input wire logic clk_enable_i,
  input wire logic cal_tick_i,
  // status
  output logic busy_o,
  output logic done_o
);

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } dscal_state_e;

  localparam int CAL_CNT_W = dscal_pkg::CAL_CNT_W;

  dscal_state_e state_q;
  logic [dscal_pkg::CAL_CNT_W-1:0] tick_cnt_q;
  logic launch;
  logic last_tick;

  // a start with the clock gated off is dropped, not remembered
  assign launch = start_i && select_i && clk_enable_i;
  assign last_tick = cal_tick_i && (tick_cnt_q == CAL_CNT_W'(CAL_CYCLES - 1));

  // ************************************************************
  // run sequencing
  // ************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state_q <= ST_IDLE;
    else
    begin
      unique case (state_q)
        ST_IDLE: if (launch) state_q <= ST_RUN;
        ST_RUN: if (last_tick) state_q <= ST_DONE;
        ST_DONE: if (launch) state_q <= ST_RUN;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // tick counter only advances on calibration clock ticks
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tick_cnt_q <= '0;
    else if (launch && state_q != ST_RUN)
      tick_cnt_q <= '0;
    else if (state_q == ST_RUN && cal_tick_i)
      tick_cnt_q <= tick_cnt_q + CAL_CNT_W'(1);
  end

  assign busy_o = (state_q == ST_RUN);
  assign done_o = (state_q == ST_DONE);

  AST_DONE_AFTER_RUN: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (state_q == ST_RUN && last_tick) |=> done_o && !busy_o)
    else $error("engine did not finish on its last tick");

  AST_DONE_LOW_IN_RUN: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    launch && !busy_o |=> busy_o && !done_o ##1 !done_o)
    else $error("done flag not low after a run starts");

  AST_NO_EARLY_DONE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(done_o) |-> $past(tick_cnt_q) == CAL_CNT_W'(CAL_CYCLES - 1))
    else $error("engine finished before its tick count");

endmodule // dscal_engine

//--- verilog/dscal_ctrl.sv
// dual-channel DAC self-calibration controller with register port and code outputs
`timescale 1ns/1ps

module dscal_ctrl
#(
  parameter int DAC_BITS = dscal_pkg::DAC_BITS,
  parameter int CAL_CYCLES = dscal_pkg::CAL_RUN_CYCLES
)
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic reg_wr_en_i,
  input wire logic reg_rd_en_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // sample inputs
  input wire logic [DAC_BITS-1:0] i_code_i,
  input wire logic [DAC_BITS-1:0] q_code_i,
  // complementary output drive
  output logic [DAC_BITS-1:0] i_pos_o,
  output logic [DAC_BITS-1:0] i_neg_o,
  output logic [DAC_BITS-1:0] q_pos_o,
  output logic [DAC_BITS-1:0] q_neg_o,
  // calibration status
  output logic cal_clk_o,
  output logic i_cal_done_o,
  output logic q_cal_done_o,
  output logic cal_busy_o
);

  // ************************************************************
  // register storage
  // ************************************************************
  logic [7:0] clk_sel_ctrl_q;
  logic [7:0] run_ctrl_q;
  logic wr_clk_sel;
  logic wr_run;
  logic start_pulse;
  logic cal_tick;
  logic i_busy;
  logic q_busy;
  logic [dscal_pkg::DIVSEL_W-1:0] cal_divide_select;
  logic cal_clock_enable;
  logic i_channel_cal_select;
  logic q_channel_cal_select;
  logic [7:0] status;

  // complement against all-ones: the negative output of a full code is zero
  function automatic logic [DAC_BITS-1:0] complement_code(input logic [DAC_BITS-1:0] code);
    return {DAC_BITS{1'b1}} - code;
  endfunction

  assign wr_clk_sel = reg_wr_en_i && (reg_addr_i == dscal_pkg::CLK_SEL_CTRL_ADDR);
  assign wr_run = reg_wr_en_i && (reg_addr_i == dscal_pkg::RUN_CTRL_ADDR);

  // field extraction
  assign cal_divide_select = clk_sel_ctrl_q[dscal_pkg::DIVSEL_LSB +: dscal_pkg::DIVSEL_W];
  assign cal_clock_enable = clk_sel_ctrl_q[dscal_pkg::CLK_EN_BIT];
  assign i_channel_cal_select = clk_sel_ctrl_q[dscal_pkg::I_SEL_BIT];
  assign q_channel_cal_select = clk_sel_ctrl_q[dscal_pkg::Q_SEL_BIT];

  // clock select, clock enable and channel select register
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      clk_sel_ctrl_q <= dscal_pkg::CLK_SEL_CTRL_RST;
    else if (wr_clk_sel)
      clk_sel_ctrl_q <= reg_wdata_i;
  end

  // run control: a full write replaces every bit, so 0x00 clears the flags
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      run_ctrl_q <= dscal_pkg::RUN_CTRL_RST;
    else if (wr_run)
      run_ctrl_q <= reg_wdata_i;
  end

  // only a 0->1 write of the start bit launches; rewriting 1 does not restart
  assign start_pulse = wr_run && reg_wdata_i[dscal_pkg::START_BIT]
                       && !run_ctrl_q[dscal_pkg::START_BIT];

  // ************************************************************
  // calibration clock and channel engines
  // ************************************************************
  dscal_divider u_divider
  (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .enable_i(cal_clock_enable),
    .divide_select_i(cal_divide_select),
    .cal_tick_o(cal_tick),
    .cal_clk_o(cal_clk_o)
  );

  // separate engines so either channel can run alone or both together
  dscal_engine #(.CAL_CYCLES(CAL_CYCLES)) u_i_engine
  (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .start_i(start_pulse),
    .select_i(i_channel_cal_select),
    .clk_enable_i(cal_clock_enable),
    .cal_tick_i(cal_tick),
    .busy_o(i_busy),
    .done_o(i_cal_done_o)
  );

  dscal_engine #(.CAL_CYCLES(CAL_CYCLES)) u_q_engine
  (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .start_i(start_pulse),
    .select_i(q_channel_cal_select),
    .clk_enable_i(cal_clock_enable),
    .cal_tick_i(cal_tick),
    .busy_o(q_busy),
    .done_o(q_cal_done_o)
  );

  assign cal_busy_o = i_busy || q_busy;

  // ************************************************************
  // register read-back
  // ************************************************************
  always_comb
  begin
    status = 8'h00;
    status[dscal_pkg::I_DONE_BIT] = i_cal_done_o;
    status[dscal_pkg::Q_DONE_BIT] = q_cal_done_o;
  end

  // registered read data; unmapped addresses read 0x00
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      reg_rdata_o <= dscal_pkg::RDATA_RST;
    else if (reg_rd_en_i)
    begin
      unique case (reg_addr_i)
        dscal_pkg::CLK_SEL_CTRL_ADDR: reg_rdata_o <= clk_sel_ctrl_q;
        dscal_pkg::CAL_STATUS_ADDR: reg_rdata_o <= status;
        dscal_pkg::RUN_CTRL_ADDR: reg_rdata_o <= run_ctrl_q;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ************************************************************
  // complementary output drive
  // ************************************************************
  // codes are straight binary; one register stage for clean output timing
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      i_pos_o <= '0;
      i_neg_o <= '1;
      q_pos_o <= '0;
      q_neg_o <= '1;
    end
    else
    begin
      i_pos_o <= i_code_i;
      i_neg_o <= complement_code(i_code_i);
      q_pos_o <= q_code_i;
      q_neg_o <= complement_code(q_code_i);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  // helper: reference clocks since the last tick, tracked while enabled
  logic [dscal_pkg::PERIOD_W-1:0] gap_q;
  logic gap_valid_q;
  logic [dscal_pkg::DIVSEL_W-1:0] sel_seen_q;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      gap_q <= 12'h000;
      gap_valid_q <= 1'b0;
      sel_seen_q <= 3'h0;
    end
    else
    begin
      sel_seen_q <= cal_divide_select;
      gap_q <= cal_tick ? 12'h000 : gap_q + 12'h001;
      if (!cal_clock_enable || sel_seen_q != cal_divide_select)
        gap_valid_q <= 1'b0;
      else if (cal_tick)
        gap_valid_q <= 1'b1;
    end
  end

  AST_CAL_PERIOD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (cal_tick && gap_valid_q && sel_seen_q == cal_divide_select)
      |-> gap_q == dscal_pkg::cal_period(cal_divide_select) - 12'h001)
    else $error("calibration period does not match divide select");

  AST_RANGE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    dscal_pkg::cal_period(cal_divide_select) >= 12'd32
      && dscal_pkg::cal_period(cal_divide_select) <= 12'd2048)
    else $error("calibration period out of range");

  AST_UNCAL_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (wr_run && reg_wdata_i == 8'h00)
      |=> !run_ctrl_q[dscal_pkg::I_UNCAL_BIT] && !run_ctrl_q[dscal_pkg::Q_UNCAL_BIT])
    else $error("uncalibrate flags not cleared");

  AST_SELECT_LAUNCH: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (start_pulse && cal_clock_enable)
      |=> (i_busy == $past(i_channel_cal_select) || $past(i_busy))
        && (q_busy == $past(q_channel_cal_select) || $past(q_busy)))
    else $error("engine participation does not follow select bits");

  AST_GATED_START: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (start_pulse && !cal_clock_enable && !cal_busy_o) |=> !cal_busy_o)
    else $error("run started with calibration clock disabled");

  AST_STATUS_READ: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (reg_rd_en_i && reg_addr_i == dscal_pkg::CAL_STATUS_ADDR)
      |=> reg_rdata_o == {$past(q_cal_done_o), $past(i_cal_done_o), 6'h00})
    else $error("status read does not show done flags");

  // the output flops still hold reset values one edge after release, so skip that edge
  AST_COMPLEMENT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $past(rst_b_i) |-> (i_pos_o == $past(i_code_i))
      && (i_neg_o == complement_code($past(i_code_i)))
      && (q_neg_o == complement_code(q_pos_o)))
    else $error("output pair not complementary to input code");

  AST_NEG_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ($past(rst_b_i) && $past(q_code_i) == {DAC_BITS{1'b1}}) |-> q_neg_o == '0)
    else $error("full-scale code left drive on the negative output");

  // ************************************************************
  // register port checks
  // ************************************************************
  AST_SEL_WRITE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_clk_sel |=> clk_sel_ctrl_q == $past(reg_wdata_i))
    else $error("clock select register did not take the written byte");

  AST_RDATA_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !reg_rd_en_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  AST_CLK_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !$past(cal_clock_enable) |-> !cal_clk_o)
    else $error("calibration clock visible while disabled");

  AST_I_DONE_HOLDS: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (i_cal_done_o && !(start_pulse && cal_clock_enable && i_channel_cal_select))
      |=> i_cal_done_o)
    else $error("I done flag dropped without a new run");

  AST_Q_DONE_HOLDS: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (q_cal_done_o && !(start_pulse && cal_clock_enable && q_channel_cal_select))
      |=> q_cal_done_o)
    else $error("Q done flag dropped without a new run");

  // ************************************************************
  // run length checks
  // ************************************************************
  // ticks seen by each channel since its launch, counted apart from the engine
  // so that a slip in the engine's own counter shows up here
  localparam int TICK_W = dscal_pkg::CAL_CNT_W;
  logic [TICK_W-1:0] i_ticks_q;
  logic [TICK_W-1:0] q_ticks_q;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      i_ticks_q <= '0;
    else if (start_pulse && cal_clock_enable && i_channel_cal_select && !i_busy)
      i_ticks_q <= '0;
    else if (i_busy && cal_tick)
      i_ticks_q <= i_ticks_q + TICK_W'(1);
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      q_ticks_q <= '0;
    else if (start_pulse && cal_clock_enable && q_channel_cal_select && !q_busy)
      q_ticks_q <= '0;
    else if (q_busy && cal_tick)
      q_ticks_q <= q_ticks_q + TICK_W'(1);
  end

  AST_I_RUN_LENGTH: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(i_cal_done_o) |-> i_ticks_q == TICK_W'(CAL_CYCLES))
    else $error("I run length differs from the tick count");

  AST_Q_RUN_LENGTH: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(q_cal_done_o) |-> q_ticks_q == TICK_W'(CAL_CYCLES))
    else $error("Q run length differs from the tick count");

endmodule // dscal_ctrl

//--- testbench/dscal_host_model.sv
// host model that drives the calibration controller's register port
`timescale 1ns/1ps

module dscal_host_model
(
  // clock
  input wire logic ref_clk_i,
  // register port drive
  output logic reg_wr_en_o,
  output logic reg_rd_en_o,
  output logic [4:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  // ******************
  // bus cycles
  // ******************
  // idle port at time zero
  initial
  begin
    reg_wr_en_o = 1'b0;
    reg_rd_en_o = 1'b0;
    reg_addr_o = 5'h00;
    reg_wdata_o = 8'h00;
  end

  // one strobe held over one edge; data inverted after release so nothing stale shows
  task automatic write_reg(input logic [4:0] addr, input logic [7:0] data);
    @(posedge ref_clk_i);
    reg_wr_en_o <= 1'b1;
    reg_addr_o <= addr;
    reg_wdata_o <= data;
    @(posedge ref_clk_i);
    reg_wr_en_o <= 1'b0;
    reg_wdata_o <= ~data;
  endtask

  // read strobe; the bench collects the byte a cycle later
  task automatic read_reg(input logic [4:0] addr);
    @(posedge ref_clk_i);
    reg_rd_en_o <= 1'b1;
    reg_addr_o <= addr;
    @(posedge ref_clk_i);
    reg_rd_en_o <= 1'b0;
  endtask

  // launch in the documented order; code 0 gives 3.125 MHz, inside the safe band
  task automatic start_cal(input logic [1:0] sel, input logic [2:0] div);
    write_reg(dscal_pkg::RUN_CTRL_ADDR, 8'h00);
    write_reg(dscal_pkg::CLK_SEL_CTRL_ADDR, {5'h00, div});
    write_reg(dscal_pkg::CLK_SEL_CTRL_ADDR, {5'h01, div});
    write_reg(dscal_pkg::CLK_SEL_CTRL_ADDR, {2'h0, sel, 1'b1, div});
    write_reg(dscal_pkg::RUN_CTRL_ADDR, 8'h10);
  endtask

  // wind down once the selected channels have finished
  task automatic finish_cal(input logic [1:0] sel, input logic [2:0] div);
    write_reg(dscal_pkg::RUN_CTRL_ADDR, 8'h00);
    write_reg(dscal_pkg::CLK_SEL_CTRL_ADDR, {2'h0, sel, 1'b0, div});
  endtask
endmodule // dscal_host_model

//--- testbench/dual_dac_self_calibration_ctrl_tb.sv
// self-checking testbench for the dual-channel calibration controller
`timescale 1ns/1ps

module dual_dac_self_calibration_ctrl_tb;
  localparam int NB = 10;
  localparam int CAL_N = 3;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic reg_wr_en;
  logic reg_rd_en;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_o;
  logic [NB-1:0] i_code = '0;
  logic [NB-1:0] q_code = '0;
  logic [NB-1:0] i_exp = '0;
  logic [NB-1:0] q_exp = '0;
  logic [NB-1:0] i_pos_o;
  logic [NB-1:0] i_neg_o;
  logic [NB-1:0] q_pos_o;
  logic [NB-1:0] q_neg_o;
  logic cal_clk_o;
  logic i_cal_done_o;
  logic q_cal_done_o;
  logic cal_busy_o;
  logic rd_dly = 1'b0;
  logic code_ok = 1'b0;
  logic exp_i;
  logic exp_q;
  logic [7:0] rd_q[$];
  int seed;
  int n;
  int error_cnt = 0;
  int checked = 0;

  // ******************
  // harness
  // ******************
  // 100 MHz reference clock
  always #5 ref_clk_i = ~ref_clk_i;

  dscal_host_model host_u (.ref_clk_i(ref_clk_i), .reg_wr_en_o(reg_wr_en),
    .reg_rd_en_o(reg_rd_en), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

  dscal_ctrl #(.DAC_BITS(NB), .CAL_CYCLES(CAL_N)) dut_u (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .reg_wr_en_i(reg_wr_en), .reg_rd_en_i(reg_rd_en),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata_o),
    .i_code_i(i_code), .q_code_i(q_code), .i_pos_o(i_pos_o), .i_neg_o(i_neg_o),
    .q_pos_o(q_pos_o), .q_neg_o(q_neg_o), .cal_clk_o(cal_clk_o),
    .i_cal_done_o(i_cal_done_o), .q_cal_done_o(q_cal_done_o), .cal_busy_o(cal_busy_o));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // note the expected byte, then strobe the read
  task automatic rd(input logic [4:0] addr, input logic [7:0] exp);
    rd_q.push_back(exp);
    host_u.read_reg(addr);
  endtask

  // counts cycles up to the next rise of the calibration clock view
  task automatic wait_rise(output int cnt);
    logic prev;
    cnt = 0;
    do
    begin
      prev = cal_clk_o;
      @(negedge ref_clk_i);
      cnt++;
    end
    while (!(prev === 1'b0 && cal_clk_o === 1'b1) && cnt < 5000);
    if (cnt >= 5000)
    begin
      error_cnt++;
      complete_run();
    end
  endtask

  task automatic wait_idle(output int cnt);
    cnt = 0;
    while (cal_busy_o !== 1'b0 && cnt < 5000)
    begin
      @(negedge ref_clk_i);
      cnt++;
    end
    if (cnt >= 5000)
    begin
      error_cnt++;
      complete_run();
    end
  endtask

  // random codes each edge; the code seen at an edge is what the outputs must carry
  always @(posedge ref_clk_i)
  begin
    rd_dly <= reg_rd_en;
    code_ok <= rst_b_i;
    i_exp <= i_code;
    q_exp <= q_code;
    i_code <= NB'($random(seed));
    q_code <= NB'($random(seed));
  end

  // result watcher: outputs settle by the falling edge
  always @(negedge ref_clk_i)
  begin
    if (code_ok)
    begin
      check(16'(i_pos_o), 16'(i_exp));
      check(16'(i_neg_o), 16'(NB'(~i_exp)));
      check(16'(q_pos_o), 16'(q_exp));
      check(16'(q_neg_o), 16'(NB'(~q_exp)));
    end
    if (rd_dly)
      check(16'(reg_rdata_o), 16'(rd_q.pop_front()));
  end

  // ******************
  // scenarios
  // ******************
  initial
  begin
    seed = 33;
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    // reset contents, read-only status and an unmapped place
    rd(dscal_pkg::CLK_SEL_CTRL_ADDR, 8'h00);
    rd(dscal_pkg::RUN_CTRL_ADDR, 8'h00);
    host_u.write_reg(dscal_pkg::CAL_STATUS_ADDR, 8'hFF);
    rd(dscal_pkg::CAL_STATUS_ADDR, 8'h00);
    rd(5'h1F, 8'h00);
    host_u.write_reg(dscal_pkg::RUN_CTRL_ADDR, 8'h03);
    rd(dscal_pkg::RUN_CTRL_ADDR, 8'h03);
    host_u.write_reg(dscal_pkg::RUN_CTRL_ADDR, 8'h00);
    rd(dscal_pkg::RUN_CTRL_ADDR, 8'h00);
    $display("register test finished");
    // first rise after a code change is discarded; the top code stays at 2048
    for (int c = 0; c < 8; c++)
    begin
      host_u.write_reg(dscal_pkg::CLK_SEL_CTRL_ADDR, 8'(8'h08 | c));
      wait_rise(n);
      wait_rise(n);
      check(16'(n), 16'(32 << ((c < 7) ? c : 6)));
    end
    host_u.write_reg(dscal_pkg::CLK_SEL_CTRL_ADDR, 8'h00);
    repeat (4) @(negedge ref_clk_i);
    repeat (64)
    begin
      @(negedge ref_clk_i);
      check(16'(cal_clk_o), 16'h0);
    end
    $display("divider test finished");
    // start with the clock gated off is dropped, not remembered
    host_u.write_reg(dscal_pkg::CLK_SEL_CTRL_ADDR, 8'h10);
    host_u.write_reg(dscal_pkg::RUN_CTRL_ADDR, 8'h10);
    @(negedge ref_clk_i);
    check(16'(cal_busy_o), 16'h0);
    host_u.write_reg(dscal_pkg::CLK_SEL_CTRL_ADDR, 8'h18);
    repeat (100) @(negedge ref_clk_i);
    check(16'(cal_busy_o), 16'h0);
    check(16'(i_cal_done_o), 16'h0);
    $display("gated start test finished");
    // I alone, Q alone, then both together
    exp_i = 1'b0;
    exp_q = 1'b0;
    for (int s = 1; s < 4; s++)
    begin
      host_u.start_cal(2'(s), 3'h0);
      @(negedge ref_clk_i);
      check(16'(cal_busy_o), 16'h1);
      check(16'(i_cal_done_o), 16'(s[0] ? 1'b0 : exp_i));
      check(16'(q_cal_done_o), 16'(s[1] ? 1'b0 : exp_q));
      wait_idle(n);
      check(16'(n >= 64 && n <= 140), 16'h1);
      exp_i = exp_i | s[0];
      exp_q = exp_q | s[1];
      check(16'({q_cal_done_o, i_cal_done_o}), 16'({exp_q, exp_i}));
      rd(dscal_pkg::CAL_STATUS_ADDR, {exp_q, exp_i, 6'h00});
      host_u.finish_cal(2'(s), 3'h0);
      rd(dscal_pkg::CAL_STATUS_ADDR, {exp_q, exp_i, 6'h00});
      rd(dscal_pkg::CLK_SEL_CTRL_ADDR, {2'h0, 2'(s), 4'h0});
    end
    $display("calibration run test finished");
    repeat (4) @(negedge ref_clk_i);
    complete_run();
  end
endmodule // dual_dac_self_calibration_ctrl_tb
